// File: rtl/dcf_pkg.sv
// constants shared by both ends of the single-clock fifo link
// assumes one clock, pclk at 25 MHz, shared by writer and reader
//
// How it works
// - read enable low, not empty: next word out
// - load mode read shows offset register instead
// - cascade out pin: half full, else cascade
// - empty flag low when no words held
// - full flag low at maximum word count
// - almost empty low at or below offset
// - sync mode: almost empty on read edges
// - almost full low within offset of full
// - sync mode: almost full on write edges
// - load mode ports reach the offset register
// - chain: first device first load low only
// - single or width use: first load low
// - retransmit strobe rewinds the read position, outside a chain only
// - chain read cascade out feeds next in
// - reset empties buffer, clears both positions
// - reset applied after power-up before use
// - output enable low drives, high floats
// - write enable low, not full: store word
// - load mode write stores offset register
// - empty on read edges, full on write
package dcf_pkg;
   // data path and depth
   localparam int DCF_WIDTH = 18;
   localparam int DCF_DEPTH = 8192;
   // offset register values after reset
   localparam int DCF_AE_OFF_RST = 7;
   localparam int DCF_AF_OFF_RST = 7;
   // apb register byte offsets
   localparam logic [11:0] DCF_REG_CTRL = 12'h000;
   localparam logic [11:0] DCF_REG_WDATA = 12'h004;
   localparam logic [11:0] DCF_REG_RCMD = 12'h008;
   localparam logic [11:0] DCF_REG_RDATA = 12'h00c;
   localparam logic [11:0] DCF_REG_STATUS = 12'h010;
   // control register bit positions
   localparam int DCF_CTRL_LOAD = 0;
   localparam int DCF_CTRL_SYNC = 1;
   localparam int DCF_CTRL_OE = 2;
   localparam int DCF_CTRL_FL = 3;
   localparam int DCF_CTRL_RST = 4;
   localparam int DCF_CTRL_RT = 5;
   localparam int DCF_CTRL_W = 4;
   // control register value after reset: outputs driven
   localparam logic [3:0] DCF_CTRL_RST_VAL = 4'h4;
   // offset register selector
   typedef enum logic [1:0] {
      DCF_SEL_AE = 2'b01,
      DCF_SEL_AF = 2'b10
   } dcf_sel_t;
endpackage

// File: rtl/dcf_if.sv
// pin bundle between the fifo device and its producer/consumer
// assumes both ends run on the same pclk; two-way data is split
`timescale 1ns/1ps
interface dcf_if;
   logic [17:0] data_in; // word toward the fifo
   logic write_en_n; // store strobe, low active
   logic read_en_n; // fetch strobe, low active
   logic offset_load_n; // low selects the offset register
   logic [17:0] data_out; // word from the fifo
   logic data_out_oe; // high while the fifo drives data_out
   logic output_enable_n; // low lets the fifo drive data_out
   logic empty_flag_n; // low when empty
   logic full_flag_n; // low when full
   logic almost_empty_flag_n; // low when almost empty
   logic almost_full_flag_n; // low when almost full
   logic write_cascade_out_n; // half full, or cascade pulse
   logic first_load_n; // low on the device taking first write
   logic retransmit_strobe; // high pulse rewinds reading
   logic reset_n; // low empties the fifo
   logic flag_sync_select_n; // low: almost flags lag one edge
   modport dev (
      input data_in, write_en_n, read_en_n, offset_load_n,
      output_enable_n, first_load_n, retransmit_strobe, reset_n,
      flag_sync_select_n,
      output data_out, data_out_oe, empty_flag_n, full_flag_n,
      almost_empty_flag_n, almost_full_flag_n, write_cascade_out_n
   );
   modport host (
      output data_in, write_en_n, read_en_n, offset_load_n,
      output_enable_n, first_load_n, retransmit_strobe, reset_n,
      flag_sync_select_n,
      input data_out, data_out_oe, empty_flag_n, full_flag_n,
      almost_empty_flag_n, almost_full_flag_n, write_cascade_out_n
   );
endinterface

// File: rtl/dcf_flag_cmp.sv
// level comparator giving the five status flags for one fill level
// assumes offsets are no larger than the depth
`timescale 1ns/1ps
module dcf_flag_cmp
   import dcf_pkg::*;
#(
   parameter int DEPTH = DCF_DEPTH,
   parameter int PW = 13,
   parameter int CW = 14
)
(
   input logic [CW-1:0] level,
   input logic [PW-1:0] ae_off,
   input logic [PW-1:0] af_off,
   output logic empty_n,
   output logic full_n,
   output logic ae_n,
   output logic af_n,
   output logic hf_n
);
   localparam logic [CW-1:0] FULL = CW'(DEPTH);
   localparam logic [CW-1:0] HALF = CW'(DEPTH / 2);
   // empty when nothing held
   assign empty_n = (level != '0);
   // full when the maximum word count is held
   assign full_n = (level != FULL);
   // almost empty at or below the programmed offset
   assign ae_n = (level > CW'(ae_off));
   // almost full once within the offset of full
   assign af_n = (level < (FULL - CW'(af_off)));
   // half full above half the depth
   assign hf_n = (level <= HALF);
endmodule

// File: rtl/dcf_fifo_dev.sv
// fifo device end: storage, offset register, flags and cascading
// assumes the producer and consumer share pclk with this block;
// cascade pins join neighbouring devices, wired by the bench
`timescale 1ns/1ps
module dcf_fifo_dev
   import dcf_pkg::*;
#(
   parameter int DEPTH = DCF_DEPTH,
   parameter bit CASCADE = 1'b0
)
(
   input logic pclk,
   input logic presetn,
   dcf_if.dev lnk,
   input logic write_cascade_in_n,
   input logic read_cascade_in_n,
   output logic read_cascade_out_n
);
   localparam int PW = $clog2(DEPTH);
   localparam int CW = $clog2(DEPTH + 1);
   localparam logic [CW-1:0] FULL = CW'(DEPTH);

   // word storage, flip-flops indexed by position
   logic [DCF_WIDTH-1:0] mem [DEPTH];
   // write and read positions
   logic [PW-1:0] wr_ptr_r, rd_ptr_r;
   // words held now and after this edge
   logic [CW-1:0] count_r, count_nxt;
   // level that a rewind restores
   logic [CW-1:0] rt_level;
   // programmable offsets
   logic [PW-1:0] ae_off_r, af_off_r;
   // which offset the next load access reaches
   dcf_sel_t sel_r;
   // cascade tokens: this device may write / read
   logic wr_tok_r, rd_tok_r;
   // qualified operations of this edge
   logic do_wr, do_rd, do_rt, off_wr, off_rd;
   // flags computed from next and present level
   logic nx_empty_n, nx_full_n, nx_ae_n, nx_af_n, nx_hf_n;
   logic pr_ae_n, pr_af_n;
   // registered outputs
   logic [DCF_WIDTH-1:0] data_out_r;
   logic data_out_oe_r, empty_r, full_r, ae_r, af_r, wxo_r, rxo_r;

   // a device outside a chain always owns both directions
   assign do_wr = ~lnk.write_en_n & lnk.offset_load_n
      & (count_r != FULL) & (wr_tok_r | ~CASCADE);
   assign do_rt = lnk.retransmit_strobe & ~CASCADE;
   assign do_rd = ~lnk.read_en_n & lnk.offset_load_n & ~do_rt
      & (count_r != '0) & (rd_tok_r | ~CASCADE);
   assign off_wr = ~lnk.write_en_n & ~lnk.offset_load_n;
   assign off_rd = ~lnk.read_en_n & ~lnk.offset_load_n;

   // a wrapped write position means the whole store was filled
   assign rt_level = (wr_ptr_r == '0) ? count_r : CW'(wr_ptr_r);

   // next fill level: a rewind makes everything written since reset
   // unread again, otherwise a simultaneous read and write cancel
   assign count_nxt = do_rt ? rt_level + CW'(do_wr)
      : count_r + CW'(do_wr) - CW'(do_rd);

   // flags for the level after this edge
   dcf_flag_cmp #(.DEPTH(DEPTH), .PW(PW), .CW(CW)) u_cmp_next (
      .level(count_nxt),
      .ae_off(ae_off_r),
      .af_off(af_off_r),
      .empty_n(nx_empty_n),
      .full_n(nx_full_n),
      .ae_n(nx_ae_n),
      .af_n(nx_af_n),
      .hf_n(nx_hf_n)
   );

   // flags for the level before this edge, used in sync mode
   dcf_flag_cmp #(.DEPTH(DEPTH), .PW(PW), .CW(CW)) u_cmp_prev (
      .level(count_r),
      .ae_off(ae_off_r),
      .af_off(af_off_r),
      .empty_n(),
      .full_n(),
      .ae_n(pr_ae_n),
      .af_n(pr_af_n),
      .hf_n()
   );

   // storage write, no reset needed on data
   always_ff @(posedge pclk)
   begin
      if (do_wr)
      begin
         mem[wr_ptr_r] <= lnk.data_in;
      end
   end

   // positions and level
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         wr_ptr_r <= '0;
         rd_ptr_r <= '0;
         count_r <= '0;
      end
      else if (!lnk.reset_n)
      begin
         // reset pin returns the device to empty
         wr_ptr_r <= '0;
         rd_ptr_r <= '0;
         count_r <= '0;
      end
      else
      begin
         wr_ptr_r <= wr_ptr_r + PW'(do_wr);
         // a rewind restarts reading at the first slot
         rd_ptr_r <= do_rt ? '0 : rd_ptr_r + PW'(do_rd);
         count_r <= count_nxt;
      end
   end

   // offset register and its access selector
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         ae_off_r <= PW'(DCF_AE_OFF_RST);
         af_off_r <= PW'(DCF_AF_OFF_RST);
         sel_r <= DCF_SEL_AE;
      end
      else if (!lnk.reset_n)
      begin
         // reset restores the default offsets
         ae_off_r <= PW'(DCF_AE_OFF_RST);
         af_off_r <= PW'(DCF_AF_OFF_RST);
         sel_r <= DCF_SEL_AE;
      end
      else
      begin
         if (off_wr)
         begin
            // write goes to the selected offset
            unique case (sel_r)
               DCF_SEL_AE: ae_off_r <= lnk.data_in[PW-1:0];
               DCF_SEL_AF: af_off_r <= lnk.data_in[PW-1:0];
            endcase
         end
         if (off_wr || off_rd)
         begin
            // alternate, wrapping after the almost full offset
            sel_r <= (sel_r == DCF_SEL_AE) ? DCF_SEL_AF
               : DCF_SEL_AE;
         end
      end
   end

   // output word: stored data or offset readback
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         data_out_r <= '0;
      end
      else if (off_rd)
      begin
         // load mode read shows the selected offset
         data_out_r <= (sel_r == DCF_SEL_AE)
            ? DCF_WIDTH'(ae_off_r)
            : DCF_WIDTH'(af_off_r);
      end
      else if (do_rd)
      begin
         data_out_r <= mem[rd_ptr_r];
      end
   end

   // output driver enable follows the enable pin
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         data_out_oe_r <= 1'b0;
      end
      else
      begin
         data_out_oe_r <= ~lnk.output_enable_n;
      end
   end

   // status flags; empty and full always track the new level
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         empty_r <= 1'b0;
         full_r <= 1'b1;
         ae_r <= 1'b0;
         af_r <= 1'b1;
      end
      else if (!lnk.reset_n)
      begin
         empty_r <= 1'b0;
         full_r <= 1'b1;
         ae_r <= 1'b0;
         af_r <= 1'b1;
      end
      else
      begin
         empty_r <= nx_empty_n;
         full_r <= nx_full_n;
         // async mode tracks at once, sync mode lags one edge
         ae_r <= lnk.flag_sync_select_n ? nx_ae_n
            : pr_ae_n;
         af_r <= lnk.flag_sync_select_n ? nx_af_n
            : pr_af_n;
      end
   end

   // cascade tokens and pulses; strap sampled while reset held
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         wr_tok_r <= 1'b0;
         rd_tok_r <= 1'b0;
         wxo_r <= 1'b1;
         rxo_r <= 1'b1;
      end
      else if (!lnk.reset_n)
      begin
         // the first device of a chain starts with both tokens
         wr_tok_r <= ~lnk.first_load_n;
         rd_tok_r <= ~lnk.first_load_n;
         wxo_r <= 1'b1;
         rxo_r <= 1'b1;
      end
      else if (CASCADE)
      begin
         // hand writing on when this device fills up
         wxo_r <= ~(do_wr && count_nxt == FULL);
         // give the token away on filling, take it on a neighbour pulse
         wr_tok_r <= ~(do_wr && count_nxt == FULL)
            & (wr_tok_r | ~write_cascade_in_n);
         // hand reading on when this device runs dry
         rxo_r <= ~(do_rd && count_nxt == '0);
         rd_tok_r <= ~(do_rd && count_nxt == '0)
            & (rd_tok_r | ~read_cascade_in_n);
      end
      else
      begin
         // alone or width expanded the pin shows half full
         wxo_r <= nx_hf_n;
         rxo_r <= 1'b1;
      end
   end

   // pins
   assign lnk.data_out = data_out_r;
   assign lnk.data_out_oe = data_out_oe_r;
   assign lnk.empty_flag_n = empty_r;
   assign lnk.full_flag_n = full_r;
   assign lnk.almost_empty_flag_n = ae_r;
   assign lnk.almost_full_flag_n = af_r;
   assign lnk.write_cascade_out_n = wxo_r;
   assign read_cascade_out_n = rxo_r;
endmodule

// File: rtl/dcf_host.sv
// producer/consumer end: apb slave that drives the fifo pins
// assumes the fifo shares pclk; apb master follows apb3 timing
`timescale 1ns/1ps
module dcf_host
   import dcf_pkg::*;
(
   input logic pclk,
   input logic presetn,
   input logic psel,
   input logic penable,
   input logic pwrite,
   input logic [11:0] paddr,
   input logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   dcf_if.host lnk
);
   logic pready_r; // one wait state, high on the completing edge
   logic [31:0] prdata_r; // read answer
   logic pslverr_r; // unmapped address answer
   logic [DCF_CTRL_W-1:0] ctrl_r; // load, sync, oe, first load
   logic [17:0] din_r; // word toward the fifo
   logic wen_n_r; // one-cycle write strobe
   logic ren_n_r; // one-cycle read strobe
   logic ren_d_r; // read strobe delayed to capture data_out
   logic rt_r; // one-cycle retransmit pulse
   logic rst_n_r; // fifo reset pin
   logic [17:0] rdata_r; // captured output word
   logic wr_acc; // write completes this edge
   logic setup_acc; // access cycle before the answer
   logic mapped; // address hits a register

   assign setup_acc = psel & penable & ~pready_r;
   assign wr_acc = psel & penable & pready_r & pwrite;
   assign mapped = (paddr == DCF_REG_CTRL) || (paddr == DCF_REG_WDATA)
      || (paddr == DCF_REG_RCMD) || (paddr == DCF_REG_RDATA)
      || (paddr == DCF_REG_STATUS);

   // apb answer: pready one cycle into the access phase
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         pready_r <= 1'b0;
         prdata_r <= '0;
         pslverr_r <= 1'b0;
      end
      else
      begin
         pready_r <= setup_acc;
         pslverr_r <= setup_acc & ~mapped;
         if (setup_acc && !pwrite)
         begin
            unique case (paddr)
               DCF_REG_CTRL: prdata_r <= 32'(ctrl_r);
               DCF_REG_RDATA: prdata_r <= 32'(rdata_r);
               DCF_REG_STATUS: prdata_r <= {26'h0,
                  lnk.data_out_oe, lnk.write_cascade_out_n,
                  lnk.almost_full_flag_n, lnk.almost_empty_flag_n,
                  lnk.full_flag_n, lnk.empty_flag_n};
               default: prdata_r <= '0;
            endcase
         end
      end
   end

   // control register and strobes
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         ctrl_r <= DCF_CTRL_RST_VAL; // first load low
         din_r <= '0;
         wen_n_r <= 1'b1;
         ren_n_r <= 1'b1;
         rt_r <= 1'b0;
         rst_n_r <= 1'b0; // fifo held in reset after power-up
      end
      else
      begin
         wen_n_r <= ~(wr_acc && paddr == DCF_REG_WDATA);
         ren_n_r <= ~(wr_acc && paddr == DCF_REG_RCMD);
         rt_r <= wr_acc && paddr == DCF_REG_CTRL
            && pwdata[DCF_CTRL_RT];
         rst_n_r <= ~(wr_acc && paddr == DCF_REG_CTRL
            && pwdata[DCF_CTRL_RST]);
         if (wr_acc && paddr == DCF_REG_WDATA)
         begin
            din_r <= pwdata[17:0];
         end
         if (wr_acc && paddr == DCF_REG_CTRL)
         begin
            ctrl_r <= pwdata[DCF_CTRL_W-1:0];
         end
      end
   end

   // capture the word one edge after the read strobe
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         ren_d_r <= 1'b0;
         rdata_r <= '0;
      end
      else
      begin
         ren_d_r <= ~ren_n_r;
         if (ren_d_r)
         begin
            rdata_r <= lnk.data_out;
         end
      end
   end

   assign prdata = prdata_r;
   assign pready = pready_r;
   assign pslverr = pslverr_r;
   assign lnk.data_in = din_r;
   assign lnk.write_en_n = wen_n_r;
   assign lnk.read_en_n = ren_n_r;
   assign lnk.offset_load_n = ~ctrl_r[DCF_CTRL_LOAD];
   assign lnk.flag_sync_select_n = ~ctrl_r[DCF_CTRL_SYNC];
   assign lnk.output_enable_n = ~ctrl_r[DCF_CTRL_OE];
   assign lnk.first_load_n = ctrl_r[DCF_CTRL_FL];
   assign lnk.retransmit_strobe = rt_r;
   assign lnk.reset_n = rst_n_r;
endmodule

// File: testbench/dcf_link_props.sv
// assertions on the pin link between the fifo device and its host end
// assumes one clock pclk, async low presetn; the bench instantiates it
`timescale 1ns/1ps
module dcf_link_props
(
   input logic pclk,
   input logic presetn,
   input logic [17:0] data_out,
   input logic data_out_oe,
   input logic output_enable_n,
   input logic write_en_n,
   input logic read_en_n,
   input logic offset_load_n,
   input logic empty_flag_n,
   input logic full_flag_n,
   input logic almost_empty_flag_n,
   input logic almost_full_flag_n,
   input logic write_cascade_out_n,
   input logic retransmit_strobe,
   input logic reset_n,
   input logic flag_sync_select_n
);
   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);
   logic act_now; // an event that may move level or offsets
   logic act_d1; // that event one edge ago
   logic act_d2; // that event two edges ago
   logic plain; // buffer access: no load mode, reset or rewind
   assign act_now = !write_en_n || !read_en_n || retransmit_strobe
      || !offset_load_n || !reset_n;
   assign plain = offset_load_n && reset_n && !retransmit_strobe;
   // history of events; set during reset so nothing fires at release
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         act_d1 <= 1'b1;
         act_d2 <= 1'b1;
      end
      else
      begin
         act_d1 <= act_now;
         act_d2 <= act_d1;
      end
   end
   a_empty_read_hold:
      assert property (plain && !read_en_n && write_en_n && !empty_flag_n
         |=> $stable(data_out) && !empty_flag_n)
      else $error("read of empty buffer moved output or flag");
   a_write_leaves_empty:
      assert property (plain && !write_en_n && full_flag_n |=> empty_flag_n)
      else $error("empty flag low after a stored word");
   a_read_leaves_full:
      assert property (plain && !read_en_n && empty_flag_n |=> full_flag_n)
      else $error("full flag low after a read");
   a_full_write_refused:
      assert property (plain && !write_en_n && read_en_n && !full_flag_n
         |=> !full_flag_n)
      else $error("write to full buffer changed fill");
   a_fifo_reset_flags:
      assert property (!reset_n |=> !empty_flag_n && full_flag_n
         && !almost_empty_flag_n && almost_full_flag_n && write_cascade_out_n)
      else $error("flags not at empty values after fifo reset");
   a_oe_drives:
      assert property (!output_enable_n |=> data_out_oe)
      else $error("outputs not driven with enable low");
   a_oe_floats:
      assert property (output_enable_n |=> !data_out_oe)
      else $error("outputs driven with enable high");
   a_empty_ae_low:
      assert property (flag_sync_select_n && $past(flag_sync_select_n)
         && !empty_flag_n |-> !almost_empty_flag_n)
      else $error("almost empty high while empty");
   a_full_af_low:
      assert property (flag_sync_select_n && $past(flag_sync_select_n)
         && !full_flag_n |-> !almost_full_flag_n)
      else $error("almost full high while full");
   a_half_flag_empty:
      assert property (!empty_flag_n |-> write_cascade_out_n)
      else $error("half flag low while empty");
   a_half_flag_full:
      assert property (!full_flag_n |-> !write_cascade_out_n)
      else $error("half flag high while full");
   a_sync_ae_lag:
      assert property (!flag_sync_select_n && !$past(flag_sync_select_n)
         && $changed(almost_empty_flag_n)
         |-> act_d2 || !$past(reset_n) || !$past(offset_load_n))
      else $error("synced almost empty moved without a lagged cause");
   a_sync_af_lag:
      assert property (!flag_sync_select_n && !$past(flag_sync_select_n)
         && $changed(almost_full_flag_n)
         |-> act_d2 || !$past(reset_n) || !$past(offset_load_n))
      else $error("synced almost full moved without a lagged cause");
   c_full: cover property (!full_flag_n);
   c_refused: cover property (!read_en_n && !empty_flag_n);
   c_rewind: cover property (retransmit_strobe);
   c_sync_move: cover property (!flag_sync_select_n
      && $changed(almost_full_flag_n));
endmodule

// File: testbench/testbench.sv
// self-checking bench: apb master into the host end, fifo device beyond
// assumes one 25 MHz pclk and a small device depth to reach full quickly
`timescale 1ns/1ps
module testbench
   import dcf_pkg::*;
;
   localparam int DEP = 16; // shortened depth
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr, rco_n;
   logic [11:0] paddr; // apb address
   logic [31:0] pwdata, prdata, r; // apb data and a scratch word
   logic e; // scratch error response
   int n_errors = 0;
   int n_compared = 0;
   int cycles = 0;
   dcf_if lnk();
   dcf_host dcf_host_i(.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr), .lnk(lnk));
   dcf_fifo_dev #(.DEPTH(DEP), .CASCADE(1'b0)) dcf_fifo_dev_i(.pclk(pclk),
      .presetn(presetn), .lnk(lnk), .write_cascade_in_n(1'b0),
      .read_cascade_in_n(1'b0), .read_cascade_out_n(rco_n));
   dcf_link_props dcf_link_props_i(.pclk(pclk), .presetn(presetn),
      .data_out(lnk.data_out), .data_out_oe(lnk.data_out_oe),
      .output_enable_n(lnk.output_enable_n), .write_en_n(lnk.write_en_n),
      .read_en_n(lnk.read_en_n), .offset_load_n(lnk.offset_load_n),
      .empty_flag_n(lnk.empty_flag_n), .full_flag_n(lnk.full_flag_n),
      .almost_empty_flag_n(lnk.almost_empty_flag_n),
      .almost_full_flag_n(lnk.almost_full_flag_n),
      .write_cascade_out_n(lnk.write_cascade_out_n),
      .retransmit_strobe(lnk.retransmit_strobe), .reset_n(lnk.reset_n),
      .flag_sync_select_n(lnk.flag_sync_select_n));
   // clock
   initial
   begin
      pclk = 1'b0;
      forever #20 pclk = ~pclk;
   end
   // verdict and end of run
   task report_and_stop;
      $display("mismatches %0d, comparisons %0d", n_errors, n_compared);
      if (n_errors == 0 && n_compared > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask
   // hang guard
   always @(posedge pclk)
   begin
      cycles = cycles + 1;
      if (cycles == 6000)
      begin
         n_errors = n_errors + 1;
         report_and_stop;
      end
   end
   // compare and count
   task chk(input logic [31:0] got, input logic [31:0] exp);
      n_compared = n_compared + 1;
      if (got !== exp)
      begin
         n_errors = n_errors + 1;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   // one apb transfer: setup, access, wait for pready
   task apb(input logic w, input logic [11:0] a, input logic [31:0] d,
      output logic [31:0] rd, output logic er);
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task wr(input logic [11:0] a, input logic [31:0] d);
      logic [31:0] rd;
      logic er;
      apb(1'b1, a, d, rd, er);
   endtask
   // expected status word for a fill level and offsets
   function automatic logic [31:0] exp_st(input int lvl, input int ae,
      input int af, input logic oe);
      exp_st = {26'h0, oe, lvl <= DEP / 2, lvl < DEP - af, lvl > ae,
         lvl != DEP, lvl != 0};
   endfunction
   task st(input int lvl, input int ae, input int af, input logic oe);
      apb(1'b0, DCF_REG_STATUS, 32'h0, r, e);
      chk(r & 32'h3f, exp_st(lvl, ae, af, oe));
   endtask
   // read strobe, let the word land, then fetch it
   task pop(output logic [31:0] rd);
      logic er;
      wr(DCF_REG_RCMD, 32'h0);
      repeat (3) @(posedge pclk);
      apb(1'b0, DCF_REG_RDATA, 32'h0, rd, er);
      rd = rd & 32'h3ffff;
   endtask
   initial
   begin
      presetn = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 12'h000;
      pwdata = 32'h0;
      repeat (20) @(posedge pclk);
      presetn <= 1'b1;
      st(0, 7, 7, 1'b1);
      apb(1'b0, 12'h014, 32'h0, r, e);
      chk({31'h0, e}, 32'h1);
      chk(r, 32'h0);
      // fill to the brim, every level checked
      for (int i = 0; i < DEP; i++)
      begin
         wr(DCF_REG_WDATA, 32'h2a5a0 + i);
         st(i + 1, 7, 7, 1'b1);
      end
      wr(DCF_REG_WDATA, 32'h01234);
      st(DEP, 7, 7, 1'b1);
      // drain in order, then one read too many
      for (int i = 0; i < DEP; i++)
      begin
         pop(r);
         chk(r, 32'h2a5a0 + i);
         st(DEP - 1 - i, 7, 7, 1'b1);
      end
      pop(r);
      chk(r, 32'h2a5af);
      st(0, 7, 7, 1'b1);
      // fifo reset, then offsets through the data ports
      wr(DCF_REG_CTRL, 32'h14);
      st(0, 7, 7, 1'b1);
      wr(DCF_REG_CTRL, 32'h7);
      wr(DCF_REG_WDATA, 32'h3);
      wr(DCF_REG_WDATA, 32'hc);
      pop(r);
      chk(r, 32'h3);
      pop(r);
      chk(r, 32'hc);
      wr(DCF_REG_CTRL, 32'h6);
      st(0, 3, 12, 1'b1);
      // synced flags across the new thresholds
      for (int i = 0; i < 4; i++)
      begin
         wr(DCF_REG_WDATA, 32'h15000 + i);
         st(i + 1, 3, 12, 1'b1);
      end
      pop(r);
      chk(r, 32'h15000);
      pop(r);
      chk(r, 32'h15001);
      st(2, 3, 12, 1'b1);
      // rewind replays from the first word
      wr(DCF_REG_CTRL, 32'h26);
      st(4, 3, 12, 1'b1);
      pop(r);
      chk(r, 32'h15000);
      // outputs released, then driven again
      wr(DCF_REG_CTRL, 32'h0);
      st(3, 3, 12, 1'b0);
      wr(DCF_REG_CTRL, 32'h4);
      st(3, 3, 12, 1'b1);
      chk({31'h0, rco_n}, 32'h1);
      report_and_stop;
   end
endmodule
